// ### power_seq_regs.svh
// Register offsets, field positions, reset values and timing counts for the power sequencer
`ifndef POWER_SEQ_REGS_SVH
`define POWER_SEQ_REGS_SVH

// Register word addresses; the bus address counts words, not bytes
`define REG_CTRL_ADDR 4'h0
`define REG_PDN_ADDR 4'h1
`define REG_STATUS_ADDR 4'h2
`define REG_RATIO_ADDR 4'h3

// Control register fields
`define CTRL_SUPPLY_BIT 0
`define CTRL_RAMP_BIT 1
`define CTRL_CLKCFG_LSB 4
`define CTRL_CLKCFG_MSB 6

// Reset values
`define CTRL_RESET 32'h0000_0000
`define PDN_RESET 8'hff

// Timing: 2 ms fixed wait, then 3000 master-clock periods
`define ADDR_WAIT_NS 2000000
`define SYS_CLK_NS 8
`define ADDR_WAIT_CYCLES (`ADDR_WAIT_NS / `SYS_CLK_NS)
`define ADDR_MCLK_COUNT 3000

`endif

// ### power_seq_pkg.sv
// Types shared by the power sequencer
package power_seq_pkg;
	typedef enum logic [2:0] {
		ST_RESET,
		ST_ADDR_WAIT,
		ST_ADDR_MCLK,
		ST_REF_UP,
		ST_CONV_UP,
		ST_RUNNING,
		ST_POWER_DOWN
	} seq_state_t;

	typedef enum logic [1:0] {
		MODE_RESET,
		MODE_POWER_DOWN,
		MODE_RUNNING,
		MODE_MIXED
	} dev_mode_t;
endpackage

// ### codec_power_sequencer.sv
// Reset, power-up and power-down sequencer with Avalon-MM register slave
`timescale 1ns/1ps
`include "power_seq_regs.svh"

module codec_power_sequencer #(
	parameter int CHANNELS = 8,
	parameter int RATIO_W = 12,
	parameter int WAIT_CYCLES = `ADDR_WAIT_CYCLES,
	parameter int MCLK_COUNT = `ADDR_MCLK_COUNT
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Pins from the host, asynchronous to sys_clk
	input wire logic master_clock,
	input wire logic frame_sync_clock,
	input wire logic addr_strap_zero,
	input wire logic addr_strap_one,
	input wire logic second_serial_output,
	input wire logic quiescent_ready,
	// Avalon-MM slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Analog control
	output logic reference_enable,
	output logic [CHANNELS-1:0] converter_power,
	output logic output_clamp,
	output logic quiescent_ramp_down,
	output logic analog_supply_select,
	output logic mute,
	output logic [2:0] latched_address,
	output logic address_latched
);

	// One counter serves both latch phases, so it is sized for the longer of the two
	localparam int CNT_MAX = (WAIT_CYCLES > MCLK_COUNT) ? WAIT_CYCLES : MCLK_COUNT;
	localparam int CNT_W = $clog2(CNT_MAX + 1);

	// Two-flop synchronisers for pins
	logic [5:0] sync1_reg, sync2_reg, sync3_reg;
	logic mclk_s, fs_s, mclk_rise, fs_rise;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_reg <= 6'h00;
			sync2_reg <= 6'h00;
			sync3_reg <= 6'h00;
		end else begin
			sync1_reg <= {quiescent_ready, second_serial_output, addr_strap_one, addr_strap_zero,
				frame_sync_clock, master_clock};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end
	// Only the second stage and the edge stage feed logic
	assign mclk_s = sync2_reg[0];
	assign fs_s = sync2_reg[1];
	assign mclk_rise = sync2_reg[0] & ~sync3_reg[0];
	assign fs_rise = sync2_reg[1] & ~sync3_reg[1];

	// Registers and sequencer state
	power_seq_pkg::seq_state_t state_reg, state_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic [2:0] addr_reg, addr_next;
	logic latched_reg, latched_next;
	logic [31:0] ctrl_reg, ctrl_next;
	logic [CHANNELS-1:0] pdn_reg, pdn_next;
	logic [RATIO_W-1:0] fcnt_reg, fcnt_next, ratio_reg, ratio_next;
	logic fs_seen_reg, fs_seen_next;
	logic mute_reg, mute_next;
	logic [31:0] rdata_reg, rdata_next;
	logic ack_reg, ack_next;

	// Mode seen by software
	function automatic power_seq_pkg::dev_mode_t mode_of(input logic [CHANNELS-1:0] pdn);
		if (&pdn)
			return power_seq_pkg::MODE_POWER_DOWN;
		else if (pdn == '0)
			return power_seq_pkg::MODE_RUNNING;
		else
			return power_seq_pkg::MODE_MIXED;
	endfunction

	logic any_up, access, wr_hit;
	assign any_up = ~&pdn_reg;
	// Requests before the latch still complete on the bus but have no effect
	assign access = (avs_read | avs_write) & latched_reg;
	// Write lands at the edge where the master sees waitrequest low, never during the wait state
	assign wr_hit = avs_write & ack_reg & latched_reg;

	// Serial clock settings differ between two control words
	function automatic logic clk_cfg_changed(input logic [31:0] new_ctrl, input logic [31:0] old_ctrl);
		return new_ctrl[`CTRL_CLKCFG_MSB:`CTRL_CLKCFG_LSB] != old_ctrl[`CTRL_CLKCFG_MSB:`CTRL_CLKCFG_LSB];
	endfunction

	// Sequencer and counters
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		addr_next = addr_reg;
		latched_next = latched_reg;
		case (state_reg)
			power_seq_pkg::ST_RESET: begin
				// One cycle here restarts the wait counter cleanly after every reset
				state_next = power_seq_pkg::ST_ADDR_WAIT;
				cnt_next = '0;
			end
			power_seq_pkg::ST_ADDR_WAIT: begin
				// Fixed interval first, counted on sys_clk
				if (cnt_reg == CNT_W'(WAIT_CYCLES - 1)) begin
					state_next = power_seq_pkg::ST_ADDR_MCLK;
					cnt_next = '0;
				end else begin
					cnt_next = cnt_reg + 1'b1;
				end
			end
			power_seq_pkg::ST_ADDR_MCLK: begin
				// Then master-clock periods, counted on synchronised rising edges
				if (mclk_rise) begin
					if (cnt_reg == CNT_W'(MCLK_COUNT - 1)) begin
						// Straps have long settled here, so one synchronised sample is enough
						addr_next = {sync2_reg[4], sync2_reg[3], sync2_reg[2]};
						latched_next = 1'b1;
						state_next = power_seq_pkg::ST_POWER_DOWN;
						cnt_next = '0;
					end else begin
						cnt_next = cnt_reg + 1'b1;
					end
				end
			end
			power_seq_pkg::ST_POWER_DOWN: begin
				// A high synchronised level is taken as proof that the master clock runs
				if (any_up && mclk_s)
					state_next = power_seq_pkg::ST_REF_UP;
			end
			power_seq_pkg::ST_REF_UP: begin
				// Quiescent node must reach its level before converters power
				if (!any_up)
					state_next = power_seq_pkg::ST_POWER_DOWN;
				else if (sync2_reg[5])
					state_next = power_seq_pkg::ST_CONV_UP;
			end
			power_seq_pkg::ST_CONV_UP: begin
				// Converters get one cycle of power before the clamps open
				state_next = any_up ? power_seq_pkg::ST_RUNNING : power_seq_pkg::ST_POWER_DOWN;
			end
			power_seq_pkg::ST_RUNNING: begin
				if (!any_up)
					state_next = power_seq_pkg::ST_POWER_DOWN;
				else if (!sync2_reg[5])
					state_next = power_seq_pkg::ST_REF_UP;
			end
			default: state_next = power_seq_pkg::ST_RESET;
		endcase
	end

	// Sequencer state and latch registers
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= power_seq_pkg::ST_RESET;
			cnt_reg <= '0;
			addr_reg <= 3'h0;
			latched_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			addr_reg <= addr_next;
			latched_reg <= latched_next;
		end
	end

	// Frame ratio measurement: mclk edges between frame rising edges
	always_comb begin
		fcnt_next = fcnt_reg;
		ratio_next = ratio_reg;
		fs_seen_next = fs_seen_reg;
		// Counter saturates rather than wraps if the frame clock goes missing
		if (fs_rise) begin
			fs_seen_next = 1'b1;
			fcnt_next = '0;
			if (fs_seen_reg)
				ratio_next = fcnt_reg + RATIO_W'(mclk_rise);
		end else if (mclk_rise && fs_seen_reg && fcnt_reg != '1) begin
			fcnt_next = fcnt_reg + 1'b1;
		end
	end

	// Ratio measurement registers
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			fcnt_reg <= '0;
			ratio_reg <= '0;
			fs_seen_reg <= 1'b0;
		end else begin
			fcnt_reg <= fcnt_next;
			ratio_reg <= ratio_next;
			fs_seen_reg <= fs_seen_next;
		end
	end

	// Register writes and mute on illegal clock change
	always_comb begin
		ctrl_next = ctrl_reg;
		pdn_next = pdn_reg;
		mute_next = mute_reg;
		if (wr_hit && avs_address == `REG_CTRL_ADDR) begin
			ctrl_next = avs_writedata;
		end
		if (wr_hit && avs_address == `REG_PDN_ADDR) begin
			pdn_next = avs_writedata[CHANNELS-1:0];
		end
		// Mute clears once every converter is powered down
		if (&pdn_reg) begin
			mute_next = 1'b0;
		end
		// A clock change with a converter up sets mute; placed last so a set wins over a clear
		if (any_up && wr_hit && avs_address == `REG_CTRL_ADDR && clk_cfg_changed(avs_writedata, ctrl_reg)) begin
			mute_next = 1'b1;
		end
	end

	// Control, power-down and mute registers
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_reg <= `CTRL_RESET;
			pdn_reg <= {CHANNELS{1'b1}};
			mute_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			pdn_reg <= pdn_next;
			mute_reg <= mute_next;
		end
	end

	// Bus slave: one wait cycle, then answer
	always_comb begin
		ack_next = (avs_read | avs_write) & ~ack_reg;
		rdata_next = rdata_reg;
		if (avs_read && !ack_reg) begin
			rdata_next = 32'h0000_0000;
			// Status packs state, mode, address, latch flag, mute and quiescent level
			if (access) begin
				case (avs_address)
					`REG_CTRL_ADDR: rdata_next = ctrl_reg;
					`REG_PDN_ADDR: rdata_next = {{(32-CHANNELS){1'b0}}, pdn_reg};
					`REG_STATUS_ADDR: rdata_next = {21'h0, sync2_reg[5], mute_reg, latched_reg, addr_reg,
						mode_of(pdn_reg), 3'(state_reg)};
					`REG_RATIO_ADDR: rdata_next = {{(32-RATIO_W){1'b0}}, ratio_reg};
					default: rdata_next = 32'h0000_0000;
				endcase
			end
		end
	end

	// Bus answer registers
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ack_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
		end
	end

	// Waitrequest is combinational so every access costs exactly one wait state
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
	assign avs_readdata = rdata_reg;

	// Analog controls follow the sequencer; clamp released only when running
	assign reference_enable = state_reg == power_seq_pkg::ST_REF_UP || state_reg == power_seq_pkg::ST_CONV_UP ||
		state_reg == power_seq_pkg::ST_RUNNING;
	assign converter_power = (state_reg == power_seq_pkg::ST_CONV_UP || state_reg == power_seq_pkg::ST_RUNNING) ?
		~pdn_reg : '0;
	assign output_clamp = state_reg != power_seq_pkg::ST_RUNNING;

	// Plain register bits; the host owns their timing
	assign quiescent_ramp_down = ctrl_reg[`CTRL_RAMP_BIT];
	assign analog_supply_select = ctrl_reg[`CTRL_SUPPLY_BIT];
	assign mute = mute_reg;
	assign latched_address = addr_reg;
	assign address_latched = latched_reg;

endmodule

// ### host_clock_model.sv
// Host-side model driving master and frame clocks
`timescale 1ns/1ps
module host_clock_model (
	// From the bench
	input wire logic mclk_on,
	// Clock pins
	output logic master_clock,
	output logic frame_sync_clock
);
	int edge_cnt;
	// Master clock runs once applied; the bench applies it only in reset
	initial begin
		master_clock = 1'b0;
		frame_sync_clock = 1'b0;
		edge_cnt = 0;
		forever begin
			#16;
			master_clock = mclk_on & ~master_clock;
			// Frame pulse every 16 mclk, never stopped while powered up
			if (master_clock) begin
				edge_cnt = (edge_cnt + 1) % 16;
				frame_sync_clock = (edge_cnt == 0);
			end
		end
	end
endmodule

// ### codec_power_sequencer_asserts.sv
// Port checker for the power sequencer
`timescale 1ns/1ps
module codec_power_sequencer_asserts #(
	parameter int CHANNELS = 8,
	parameter int WAIT_CYCLES = 20
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Bus
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Analog control
	input wire logic reference_enable,
	input wire logic [CHANNELS-1:0] converter_power,
	input wire logic output_clamp,
	input wire logic mute,
	input wire logic address_latched
);
	logic [9:0] rel_reg;
	logic [9:0] rel_next;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// Cycles since release; saturates so a long run never wraps
	always_comb begin
		rel_next = (rel_reg == 10'h3ff) ? rel_reg : rel_reg + 10'h001;
	end
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rel_reg <= 10'h000;
		end else begin
			rel_reg <= rel_next;
		end
	end
	sequence s_req_held;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_done_write_ctrl;
		avs_write && !avs_waitrequest && avs_address == 4'h0;
	endsequence
	property p_reset_state;
		$rose(rst_b) |-> output_clamp && !reference_enable && converter_power == '0 && !address_latched;
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("not reset state");
	property p_clamp;
		!reference_enable |-> output_clamp;
	endproperty
	a_clamp: assert property (p_clamp) else $error("unclamped without reference");
	property p_ref_first;
		converter_power != '0 |-> reference_enable;
	endproperty
	a_ref_first: assert property (p_ref_first) else $error("converter before reference");
	property p_unclamp;
		$fell(output_clamp) |-> converter_power != '0;
	endproperty
	a_unclamp: assert property (p_unclamp) else $error("unclamp before converters");
	property p_latch_delay;
		$rose(address_latched) |-> int'(rel_reg) > WAIT_CYCLES;
	endproperty
	a_latch_delay: assert property (p_latch_delay) else $error("latch too early");
	property p_ignore;
		avs_read && !avs_waitrequest && !address_latched |-> avs_readdata == 32'h0;
	endproperty
	a_ignore: assert property (p_ignore) else $error("read before latch");
	property p_one_wait;
		s_req_held |=> !avs_waitrequest;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("bus answer late");
	property p_mute;
		$rose(mute) |-> $past(avs_write) && !$past(avs_waitrequest) && $past(avs_address) == 4'h0;
	endproperty
	a_mute: assert property (p_mute) else $error("mute without clock change");
	c_ctrl: cover property (s_done_write_ctrl);
endmodule

// ### codec_power_sequencer_tb_top.sv
// Self-checking bench for the power sequencer
`timescale 1ns/1ps
module codec_power_sequencer_tb_top;
	typedef struct {
		logic [3:0] a;
		logic [31:0] d;
		logic [31:0] e;
		logic [1:0] o;
	} row_t;
	logic sys_clk, rst_b, mclk_on, master_clock, frame_sync_clock, quiescent_ready;
	logic avs_read, avs_write, avs_waitrequest, reference_enable, output_clamp, mute, address_latched;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [7:0] converter_power;
	logic [2:0] latched_address;
	logic quiescent_ramp_down, analog_supply_select;
	int error_cnt = 0;
	int cmp_count = 0;
	int n;
	// Rows: address, write data, read-back, expected ramp and supply pins
	row_t rows [4] = '{'{4'h0, 32'h1, 32'h1, 2'h1}, '{4'h0, 32'h2, 32'h2, 2'h2},
		'{4'h7, 32'h5, 32'h0, 2'h2}, '{4'h0, 32'h0, 32'h0, 2'h0}};
	// Straps tied: address expected 3'h5
	codec_power_sequencer #(.WAIT_CYCLES(20), .MCLK_COUNT(5)) i_dut (
		.sys_clk(sys_clk), .rst_b(rst_b), .master_clock(master_clock), .frame_sync_clock(frame_sync_clock),
		.addr_strap_zero(1'b1), .addr_strap_one(1'b0), .second_serial_output(1'b1),
		.quiescent_ready(quiescent_ready), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .reference_enable(reference_enable),
		.converter_power(converter_power), .output_clamp(output_clamp),
		.quiescent_ramp_down(quiescent_ramp_down), .analog_supply_select(analog_supply_select),
		.mute(mute), .latched_address(latched_address),
		.address_latched(address_latched)
	);
	host_clock_model i_host (.mclk_on(mclk_on), .master_clock(master_clock), .frame_sync_clock(frame_sync_clock));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	// Holds the request until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
		int k;
		k = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= ~wr;
		do begin
			@(posedge sys_clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 100);
		if (k >= 100) error_cnt++;
		r = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic complete_run;
		$display("compares %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	// Watchdog: the tests need well under 1000 cycles
	initial begin
		repeat (5000) @(posedge sys_clk);
		error_cnt++;
		complete_run();
	end
	initial begin
		rst_b = 1'b0;
		mclk_on = 1'b0;
		quiescent_ready = 1'b0;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		repeat (2) @(posedge sys_clk);
		mclk_on <= 1'b1;
		repeat (10) @(posedge sys_clk);
		chk({output_clamp, reference_enable, converter_power}, 32'h200);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		bus(1'b1, 4'h0, 32'h3, q);
		bus(1'b0, 4'h1, 32'h0, q);
		chk(q, 32'h0);
		n = 7;
		while (address_latched !== 1'b1 && n < 500) begin
			@(posedge sys_clk);
			n++;
		end
		chk(32'(n >= 36 && n < 60), 32'h1);
		chk({29'h0, latched_address}, 32'h5);
		bus(1'b0, 4'h0, 32'h0, q);
		chk(q, 32'h0);
		bus(1'b0, 4'h2, 32'h0, q);
		chk({30'h0, q[4:3]}, 32'h1);
		$display("latch test done");
		// DC-loaded outputs stay clamped until quiescent ready
		bus(1'b1, 4'h1, 32'h0, q);
		repeat (60) @(posedge sys_clk);
		chk({31'h0, output_clamp}, 32'h1);
		quiescent_ready <= 1'b1;
		n = 0;
		while (output_clamp !== 1'b0 && n < 100) begin
			@(posedge sys_clk);
			n++;
		end
		chk({reference_enable, converter_power}, 32'h1ff);
		bus(1'b0, 4'h2, 32'h0, q);
		chk({30'h0, q[4:3]}, 32'h2);
		bus(1'b0, 4'h3, 32'h0, q);
		chk(q, 32'h10);
		$display("power-up test done");
		foreach (rows[i]) begin
			bus(1'b1, rows[i].a, rows[i].d, q);
			bus(1'b0, rows[i].a, 32'h0, q);
			chk(q, rows[i].e);
			chk({30'h0, quiescent_ramp_down, analog_supply_select}, {30'h0, rows[i].o});
		end
		bus(1'b1, 4'h0, 32'h10, q);
		chk({31'h0, mute}, 32'h1);
		bus(1'b1, 4'h1, 32'hff, q);
		// Mute clears one cycle after the power-down bits settle
		@(posedge sys_clk);
		chk({31'h0, mute}, 32'h0);
		bus(1'b1, 4'h0, 32'h2, q);
		chk({30'h0, quiescent_ramp_down, analog_supply_select}, 32'h2);
		rst_b <= 1'b0;
		@(posedge sys_clk);
		chk({output_clamp, address_latched}, 32'h2);
		$display("power-down test done");
		complete_run();
	end
endmodule
bind codec_power_sequencer codec_power_sequencer_asserts #(.CHANNELS(CHANNELS), .WAIT_CYCLES(WAIT_CYCLES)) i_chk (
	.sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .reference_enable(reference_enable),
	.converter_power(converter_power), .output_clamp(output_clamp), .mute(mute), .address_latched(address_latched)
);
